/* core/swa_pkg.sv */
// Shared constants, carriers and states for the serial wire debug target.
// Assumes nothing beyond a SystemVerilog compiler.
`default_nettype none
package swa_pkg;
    // ==========================================================
    // Acknowledge codes, sent least significant bit first
    localparam logic [2:0] ACK_OK = 3'h1;
    localparam logic [2:0] ACK_WAIT = 3'h2;
    localparam logic [2:0] ACK_FAULT = 3'h4;
    localparam logic [2:0] ACK_RESET = 3'h0;

    // ==========================================================
    // Request address field meanings on the debug port
    localparam logic [1:0] A_ID_ABORT = 2'h0;
    localparam logic [1:0] A_CTRL = 2'h1;
    localparam logic [1:0] A_RESEND_SEL = 2'h2;
    localparam logic [1:0] A_READ_BUFFER_REG = 2'h3;

    // ==========================================================
    // Control/status field positions
    localparam int CS_ORUNDETECT = 0;
    localparam int CS_STICKYORUN = 1;
    localparam int CS_TRNMODE = 2;
    localparam int CS_STICKYCMP = 4;
    localparam int CS_STICKYERR = 5;
    localparam int CS_READ_SUCCESS_FLAG = 6;
    localparam int CS_WRITE_DATA_ERROR_FLAG = 7;
    localparam logic [1:0] TRN_NORMAL = 2'h0;
    localparam logic [1:0] TRN_VERIFY = 2'h1;
    localparam logic [1:0] TRN_COMPARE = 2'h2;

    // Abort register bits
    localparam int AB_DAPABORT = 0;
    localparam int AB_STKCMPCLR = 1;
    localparam int AB_STKERRCLR = 2;
    localparam int AB_WDERRCLR = 3;
    localparam int AB_ORUNERRCLR = 4;

    // Select register fields
    localparam int SEL_CONTROL_BANK_SELECT_BIT = 0;
    localparam int SEL_BANK = 4;

    // ==========================================================
    // Reset values and frame lengths in link clock edges
    localparam logic [31:0] CS_RESET = 32'h0000_0000;
    localparam logic [31:0] SEL_RESET = 32'h0000_0000;
    localparam logic [31:0] WCR_RESET = 32'h0000_0000;
    localparam logic [5:0] REQ_BITS = 6'h08;
    localparam logic [5:0] ACK_BITS = 6'h03;
    localparam logic [5:0] DATA_BITS = 6'h21;

    // ==========================================================
    // Carriers and states
    typedef struct packed {
        logic ap;
        logic rd;
        logic [1:0] addr;
    } swa_req_t;

    typedef struct packed {
        logic wr;
        logic [5:0] addr;
        logic [31:0] wdata;
    } swa_ap_cmd_t;

    typedef enum logic [6:0] {
        ST_IDLE = 7'h01,
        ST_REQ = 7'h02,
        ST_TRN_A = 7'h04,
        ST_ACK = 7'h08,
        ST_RDAT = 7'h10,
        ST_TRN_B = 7'h20,
        ST_WDAT = 7'h40
    } swa_state_t;
endpackage : swa_pkg
`default_nettype wire

/* core/swa_sync2.sv */
// Two flip-flop synchroniser for one level.
// Assumes the input is asynchronous to clk_i.
`default_nettype none
module swa_sync2 (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic d_i,
    output logic q_o
);
    logic meta;

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            meta <= 1'b0;
            q_o <= 1'b0;
        end else begin
            meta <= d_i;
            q_o <= meta;
        end
    end
endmodule : swa_sync2
`default_nettype wire

/* core/swa_target.sv */
// Serial wire debug target: request decode, acknowledge choice,
// data phases and the debug port registers.
// Assumes an access port on clk_i and link pins from a host outside it.
// Summary of operation
// R1: Debug read at address 00 always answers OK with the identification code.
// R2: Debug read at 01 always OK; control/status or wire control by bank bit.
// R3: Resend read, clean and ready, answers OK with the last read value.
// R4: Read buffer read, clean and ready, OK, previous port result, sets read success.
// R5: These reads give WAIT if busy, FAULT if sticky; read buffer ones clear read success.
// R6: Port read, clean and ready: OK, previous result, read success set, new read.
// R7: First port read of a sequence returns an undefined value.
// R8: Port register chosen by request address plus the bank select field.
// R9: Debug write at 00 always OK and writes the abort register.
// R10: Other debug writes: OK and write, WAIT if busy, FAULT if sticky.
// R11: Writes may be accepted with OK and later abandoned.
// R12: Port write: OK and write if clean and ready, else WAIT or FAULT.
// R13: Push modes turn a port write into a compared read.
// R14: Faulty request gets no acknowledge; line stays undriven.
// R15: Write acknowledge precedes parity check; failed check sets write data error.
// R16: Every request with good parity, low stop and high park is followed by a three bit acknowledge.
// R17: Host captures read data and checks parity after OK.
// R18: Host sends write data after OK; next access confirms it.
// R19: Host repeats request after WAIT.
// R20: After FAULT only debug addresses 0X answer validly.
// R21: Host backs off after no or invalid read acknowledge.
// R22: Host backs off and repeats a write after invalid acknowledge.
// R23: Overrun detection keeps a data phase on WAIT and FAULT, undriven or discarded.
// R24: Abort register bits clear the sticky flags.
`default_nettype none
module swa_target #(
    parameter logic [31:0] ID_CODE = 32'h1357_9BDF  // Arbitrary value
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic swclk_i,
    input wire logic swdio_i,
    output logic swdio_o,
    output logic swdio_oe_o,
    output logic ap_req_o,
    output swa_pkg::swa_ap_cmd_t ap_cmd_o,
    output logic ap_abort_o,
    input wire logic ap_done_i,
    input wire logic ap_err_i,
    input wire logic [31:0] ap_rdata_i,
    output logic [31:0] ctrl_stat_o,
    output logic [31:0] select_o,
    output logic [31:0] wcr_o
);
    import swa_pkg::*;

    logic swclk_s;
    logic swdio_s;
    logic swclk_d;
    logic rise;
    swa_state_t state;
    logic [5:0] cnt;
    logic [6:0] req_sh;
    logic [6:0] next_req;
    swa_req_t req;
    logic [32:0] rx;
    logic [35:0] tx;
    logic drive;
    logic [2:0] ack;
    logic dphase;
    logic [31:0] ctrl_stat;
    logic [31:0] select;
    logic [31:0] wire_control_reg;
    logic [31:0] resend;
    logic [31:0] ap_result;
    logic ap_busy;
    logic cmp_pend;
    logic [1:0] cmp_mode;
    logic cmp_hit;
    logic fault;
    logic sticky;
    logic exempt;
    logic decide;
    logic wr_done;
    logic wpar_ok;
    logic abort_wr;
    logic rd_track;
    logic [2:0] next_ack;
    logic [31:0] next_rdata;
    logic [31:0] wd_word;

    // ==========================================================
    // Link sampling
    swa_sync2 u_sync_clk (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .d_i(swclk_i),
        .q_o(swclk_s)
    );

    swa_sync2 u_sync_dio (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .d_i(swdio_i),
        .q_o(swdio_s)
    );

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            swclk_d <= 1'b0;
        end else begin
            swclk_d <= swclk_s;
        end
    end

    // Data pin passes the same two stages, so it lines up with the edge
    assign rise = swclk_s & ~swclk_d;

    // ==========================================================
    // Response choice
    assign next_req = {swdio_s, req_sh[6:1]};
    // Even parity over four bits, stop low, park high
    assign fault = (^next_req[4:0]) | next_req[5] | ~next_req[6];
    assign sticky = ctrl_stat[CS_STICKYORUN] | ctrl_stat[CS_STICKYCMP]
                  | ctrl_stat[CS_STICKYERR] | ctrl_stat[CS_WRITE_DATA_ERROR_FLAG];
    assign exempt = ~req.ap & ((req.addr == A_ID_ABORT) | (req.rd & (req.addr == A_CTRL))); // R1 R2 R9
    assign decide = rise & (state == ST_TRN_A);
    assign rd_track = req.rd & (req.ap | (req.addr == A_READ_BUFFER_REG));

    assign next_ack = exempt ? ACK_OK : (sticky ? ACK_FAULT : (ap_busy ? ACK_WAIT : ACK_OK)); // R3 R4 R5 R6 R10 R12

    always_comb begin
        next_rdata = ap_result; // R4 R6 R7
        if (!req.ap) begin
            unique case (req.addr)
                A_ID_ABORT: next_rdata = ID_CODE; // R1
                A_CTRL: next_rdata = select[SEL_CONTROL_BANK_SELECT_BIT] ? wire_control_reg : ctrl_stat; // R2
                A_RESEND_SEL: next_rdata = resend; // R3
                A_READ_BUFFER_REG: next_rdata = ap_result; // R4
            endcase
        end
    end

    // ==========================================================
    // Link sequencing
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            state <= ST_IDLE;
            cnt <= 6'h00;
            req_sh <= 7'h00;
            req <= '0;
            rx <= 33'h0_0000_0000;
            tx <= 36'h0_0000_0000;
            drive <= 1'b0;
            ack <= ACK_RESET;
            dphase <= 1'b0;
        end else if (rise) begin
            unique case (state)
                ST_IDLE: begin
                    cnt <= 6'h00;
                    if (swdio_s) begin
                        state <= ST_REQ;
                    end
                end
                ST_REQ: begin
                    req_sh <= next_req;
                    cnt <= cnt + 6'h01;
                    if (cnt == REQ_BITS - 6'h02) begin
                        if (fault) begin
                            state <= ST_IDLE; // R14
                        end else begin
                            state <= ST_TRN_A;
                            req <= '{ap: next_req[0], rd: next_req[1], addr: {next_req[3], next_req[2]}};
                        end
                    end
                end
                ST_TRN_A: begin
                    state <= ST_ACK;
                    cnt <= 6'h00;
                    ack <= next_ack;
                    dphase <= (next_ack == ACK_OK) | ctrl_stat[CS_ORUNDETECT]; // R23
                    tx <= {^next_rdata, next_rdata, next_ack};
                    drive <= 1'b1; // R16
                end
                ST_ACK: begin
                    tx <= {1'b0, tx[35:1]};
                    cnt <= cnt + 6'h01;
                    if (cnt == ACK_BITS - 6'h01) begin
                        cnt <= 6'h00;
                        if (req.rd && dphase) begin
                            state <= ST_RDAT;
                            drive <= (ack == ACK_OK); // R23
                        end else begin
                            state <= ST_TRN_B;
                            drive <= 1'b0;
                        end
                    end
                end
                ST_RDAT: begin
                    tx <= {1'b0, tx[35:1]};
                    cnt <= cnt + 6'h01;
                    if (cnt == DATA_BITS - 6'h01) begin
                        state <= ST_TRN_B;
                        drive <= 1'b0;
                    end
                end
                ST_TRN_B: begin
                    cnt <= 6'h00;
                    state <= (!req.rd && dphase) ? ST_WDAT : ST_IDLE;
                end
                ST_WDAT: begin
                    rx <= {swdio_s, rx[32:1]};
                    cnt <= cnt + 6'h01;
                    if (cnt == DATA_BITS - 6'h01) begin
                        state <= ST_IDLE;
                    end
                end
            endcase
        end
    end

    assign swdio_o = tx[0];
    assign swdio_oe_o = drive;

    // Payload and parity complete on the last data edge
    assign wd_word = rx[32:1];
    assign wpar_ok = ~(^rx[32:1] ^ swdio_s);
    // Data after WAIT or FAULT is discarded here
    assign wr_done = rise & (state == ST_WDAT) & (cnt == DATA_BITS - 6'h01) & (ack == ACK_OK); // R23
    assign abort_wr = wr_done & wpar_ok & ~req.ap & (req.addr == A_ID_ABORT);

    // ==========================================================
    // Control/status flags
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            ctrl_stat <= CS_RESET;
        end else begin
            if (wr_done && wpar_ok && !req.ap && req.addr == A_CTRL && !select[SEL_CONTROL_BANK_SELECT_BIT]) begin
                ctrl_stat[CS_ORUNDETECT] <= wd_word[CS_ORUNDETECT]; // R10
                ctrl_stat[CS_TRNMODE +: 2] <= wd_word[CS_TRNMODE +: 2];
            end
            // Clears come first so that a same cycle set wins
            if (abort_wr) begin
                if (wd_word[AB_STKCMPCLR]) ctrl_stat[CS_STICKYCMP] <= 1'b0; // R24
                if (wd_word[AB_STKERRCLR]) ctrl_stat[CS_STICKYERR] <= 1'b0; // R24
                if (wd_word[AB_WDERRCLR]) ctrl_stat[CS_WRITE_DATA_ERROR_FLAG] <= 1'b0; // R24
                if (wd_word[AB_ORUNERRCLR]) ctrl_stat[CS_STICKYORUN] <= 1'b0; // R24
            end
            if (decide && next_ack == ACK_WAIT && ctrl_stat[CS_ORUNDETECT]) begin
                ctrl_stat[CS_STICKYORUN] <= 1'b1;
            end
            if (ap_done_i && ap_err_i) begin
                ctrl_stat[CS_STICKYERR] <= 1'b1;
            end
            if (ap_done_i && cmp_pend && cmp_hit) begin
                ctrl_stat[CS_STICKYCMP] <= 1'b1; // R13
            end
            if (wr_done && !wpar_ok) begin
                ctrl_stat[CS_WRITE_DATA_ERROR_FLAG] <= 1'b1; // R15
            end
            if (decide && rd_track) begin
                ctrl_stat[CS_READ_SUCCESS_FLAG] <= (next_ack == ACK_OK); // R4 R5 R6
            end
        end
    end

    // ==========================================================
    // Select, wire control and resend registers
    // Writes take effect only once the payload is in and checked, so an
    // OK write with bad parity is abandoned here
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            select <= SEL_RESET;
            wire_control_reg <= WCR_RESET;
            resend <= 32'h0000_0000;
        end else begin
            if (wr_done && wpar_ok && !req.ap) begin // R11
                if (req.addr == A_RESEND_SEL) select <= wd_word; // R10
                if (req.addr == A_CTRL && select[SEL_CONTROL_BANK_SELECT_BIT]) wire_control_reg <= wd_word; // R10
            end
            if (decide && rd_track && next_ack == ACK_OK) begin
                resend <= next_rdata; // R3
            end
        end
    end

    // ==========================================================
    // Access port side
    assign cmp_hit = (cmp_mode == TRN_VERIFY) ? (ap_rdata_i != ap_cmd_o.wdata)
                                              : (ap_rdata_i == ap_cmd_o.wdata);

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            ap_req_o <= 1'b0;
            ap_cmd_o <= '0;
            ap_abort_o <= 1'b0;
            ap_busy <= 1'b0;
            cmp_pend <= 1'b0;
            cmp_mode <= TRN_NORMAL;
            ap_result <= 32'h0000_0000;
        end else begin
            ap_req_o <= 1'b0;
            ap_abort_o <= 1'b0;
            if (ap_done_i) begin
                ap_busy <= 1'b0;
                cmp_pend <= 1'b0;
                if (!ap_cmd_o.wr && !cmp_pend) ap_result <= ap_rdata_i;
            end
            if (decide && req.ap && req.rd && next_ack == ACK_OK) begin
                ap_req_o <= 1'b1; // R6
                ap_cmd_o.wr <= 1'b0;
                ap_cmd_o.addr <= {select[SEL_BANK +: 4], req.addr}; // R8
                ap_busy <= 1'b1;
                cmp_pend <= 1'b0;
            end
            if (wr_done && wpar_ok && req.ap) begin
                ap_req_o <= 1'b1; // R12
                ap_cmd_o.wr <= (ctrl_stat[CS_TRNMODE +: 2] == TRN_NORMAL); // R13
                ap_cmd_o.addr <= {select[SEL_BANK +: 4], req.addr}; // R8
                ap_cmd_o.wdata <= wd_word;
                cmp_pend <= (ctrl_stat[CS_TRNMODE +: 2] != TRN_NORMAL); // R13
                cmp_mode <= ctrl_stat[CS_TRNMODE +: 2];
                ap_busy <= 1'b1;
            end
            if (abort_wr && wd_word[AB_DAPABORT]) begin
                ap_abort_o <= 1'b1;
                ap_busy <= 1'b0;
                cmp_pend <= 1'b0;
            end
        end
    end

    assign ctrl_stat_o = ctrl_stat;
    assign select_o = select;
    assign wcr_o = wire_control_reg;

    // ==========================================================
    // Assertions
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    a_identification_code_reg_read_ok: assert property (decide && !req.ap && req.rd && req.addr == A_ID_ABORT
        |=> ack == ACK_OK && tx[34:3] == ID_CODE) else $error("identification read not OK"); // R1
    a_ctrl_read_ok: assert property (decide && !req.ap && req.rd && req.addr == A_CTRL
        |=> ack == ACK_OK) else $error("control read not OK"); // R2
    a_abort_write_ok: assert property (decide && !req.ap && !req.rd && req.addr == A_ID_ABORT
        |=> ack == ACK_OK) else $error("abort write not OK"); // R9
    a_sticky_gives_fault: assert property (decide && sticky && !exempt
        |=> ack == ACK_FAULT) else $error("sticky flag without FAULT"); // R5
    a_busy_gives_wait: assert property (decide && !sticky && ap_busy && !exempt
        |=> ack == ACK_WAIT) else $error("busy port without WAIT"); // R10
    a_port_read_issue: assert property (decide && req.ap && req.rd && next_ack == ACK_OK
        |=> ap_req_o && !ap_cmd_o.wr && ap_cmd_o.addr == {$past(select[7:4]), $past(req.addr)}
        && ctrl_stat[CS_READ_SUCCESS_FLAG]) else $error("port read not issued"); // R6
    a_read_buffer_reg_read_success_flag: assert property (decide && !req.ap && req.rd && req.addr == A_READ_BUFFER_REG
        |=> ctrl_stat[CS_READ_SUCCESS_FLAG] == (ack == ACK_OK)) else $error("read success wrong"); // R4
    a_fault_silent: assert property (rise && state == ST_REQ && cnt == REQ_BITS - 6'h02 && fault
        |=> state == ST_IDLE && !swdio_oe_o [*3]) else $error("faulty request answered"); // R14
    a_parity_error: assert property (wr_done && !wpar_ok
        |=> ctrl_stat[CS_WRITE_DATA_ERROR_FLAG] && !ap_req_o) else $error("bad write parity missed"); // R15
    a_ack_driven: assert property (decide |=> swdio_oe_o && state == ST_ACK)
        else $error("acknowledge not driven"); // R16
    a_push_read: assert property (wr_done && wpar_ok && req.ap && ctrl_stat[3:2] != TRN_NORMAL
        |=> ap_req_o && !ap_cmd_o.wr && cmp_pend) else $error("push write not a read"); // R13
    a_abort_clears: assert property (abort_wr && wd_word[AB_STKERRCLR] && !ap_done_i
        |=> !ctrl_stat[CS_STICKYERR]) else $error("abort did not clear"); // R24

    c_read_ok: cover property (decide && req.rd && next_ack == ACK_OK);
    c_wait: cover property (decide && next_ack == ACK_WAIT);
    c_write_done: cover property (wr_done && wpar_ok && req.ap);
    c_fault: cover property (decide && next_ack == ACK_FAULT);
endmodule : swa_target
`default_nettype wire

/* tb/swa_host_model.sv */
// Debugger host model: drives the link clock and data, samples the target.
// Assumes the bench resolves the shared data line and feeds it back on line_i.
`default_nettype none
module swa_host_model (
    input wire logic clk_i,
    output logic swclk_o,
    output logic host_oe_o,
    output logic host_d_o,
    input wire logic line_i
);
    timeunit 1ns;
    timeprecision 1ps;
    import swa_pkg::*;
    logic orun = 1'b0;

    // ==========================================================
    // Bit timing
    initial begin
        swclk_o = 1'b0;
        host_oe_o = 1'b1;
        host_d_o = 1'b0;
    end

    // Link clock stands low between bits; 16 clk period
    task automatic edge_bit(input logic drv, input logic d, output logic smp);
        @(posedge clk_i);
        host_oe_o <= drv;
        host_d_o <= d;
        repeat (8) @(posedge clk_i);
        smp = line_i;
        swclk_o <= 1'b1;
        repeat (7) @(posedge clk_i);
        swclk_o <= 1'b0;
    endtask : edge_bit

    // ==========================================================
    // One transfer; bad[0] spoils request parity, bad[1] data parity
    task automatic xfer(input logic ap, input logic rd, input logic [1:0] a, input logic [31:0] wd,
                        input logic [1:0] bad, output logic [2:0] ack, output logic [31:0] rdat,
                        output logic pok);
        logic [7:0] req;
        logic s;
        logic dp;
        req = {1'b1, 1'b0, ^{ap, rd, a} ^ bad[0], a[1], a[0], rd, ap, 1'b1};
        rdat = 32'h0;
        pok = 1'b1;
        for (int i = 0; i < 8; i++) edge_bit(1'b1, req[i], s);
        edge_bit(1'b0, 1'b0, s);
        for (int i = 0; i < 3; i++) edge_bit(1'b0, 1'b0, ack[i]);
        dp = (ack == ACK_OK) || (orun && (ack == ACK_WAIT || ack == ACK_FAULT));
        if (dp && rd) begin
            for (int i = 0; i < 32; i++) edge_bit(1'b0, 1'b0, rdat[i]);
            edge_bit(1'b0, 1'b0, s);
            pok = (s === ^rdat);
        end else if (dp) begin
            edge_bit(1'b0, 1'b0, s);
            for (int i = 0; i < 32; i++) edge_bit(1'b1, wd[i], s);
            edge_bit(1'b1, ^wd ^ bad[1], s);
        end else if (ack == ACK_WAIT || ack == ACK_FAULT) begin
            edge_bit(1'b0, 1'b0, s);
        end else begin
            // Back off long enough to cover a data phase the target may expect
            repeat (34) edge_bit(1'b1, 1'b0, s);
        end
        edge_bit(1'b1, 1'b0, s);
    endtask : xfer
endmodule : swa_host_model
`default_nettype wire

/* tb/swa_target_tb.sv */
// Self-checking bench for the serial wire debug target.
// Assumes the host model in tb/ and a simple access port model below.
`default_nettype none
module swa_target_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import swa_pkg::*;

    localparam logic [31:0] ID_V = 32'h2468_ACE1;  // Arbitrary value
    logic clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic swclk, host_oe, host_d, line, swdio_o, swdio_oe_o, ap_req_o, ap_abort_o;
    logic ap_done_i = 1'b0;
    logic ap_err_i = 1'b0;
    logic [31:0] ap_rdata_i = 32'h0;
    logic [31:0] ctrl_stat_o, select_o, wcr_o, rd_v, ap_val;
    swa_ap_cmd_t ap_cmd_o, last_cmd;
    int mismatches = 0;
    int samples_checked = 0;
    int busy_cnt = 0;
    int ap_delay = 4;
    int n_req = 0;
    int n_abort = 0;
    logic ap_err_v = 1'b0;

    always #5 clk_i = ~clk_i;
    // Released line is pulled low so it never looks like a start bit
    assign line = swdio_oe_o ? swdio_o : (host_oe ? host_d : 1'b0);

    swa_target #(.ID_CODE(ID_V)) i_swa_target (.clk_i(clk_i), .rst_n_i(rst_n_i), .swclk_i(swclk),
        .swdio_i(line), .swdio_o(swdio_o), .swdio_oe_o(swdio_oe_o), .ap_req_o(ap_req_o), .ap_cmd_o(ap_cmd_o),
        .ap_abort_o(ap_abort_o), .ap_done_i(ap_done_i), .ap_err_i(ap_err_i), .ap_rdata_i(ap_rdata_i),
        .ctrl_stat_o(ctrl_stat_o), .select_o(select_o), .wcr_o(wcr_o));
    swa_host_model i_swa_host_model (.clk_i(clk_i), .swclk_o(swclk), .host_oe_o(host_oe), .host_d_o(host_d),
        .line_i(line));

    // ==========================================================
    // Access port model: one command at a time, done after ap_delay
    always @(posedge clk_i) begin
        ap_done_i <= 1'b0;
        if (ap_abort_o === 1'b1) begin
            n_abort <= n_abort + 1;
            busy_cnt <= 0;
        end else if (ap_req_o === 1'b1) begin
            n_req <= n_req + 1;
            last_cmd <= ap_cmd_o;
            busy_cnt <= ap_delay;
        end else if (busy_cnt == 1) begin
            ap_done_i <= 1'b1;
            ap_rdata_i <= ap_val;
            ap_err_i <= ap_err_v;
            busy_cnt <= 0;
        end else if (busy_cnt > 1) begin
            busy_cnt <= busy_cnt - 1;
        end
    end

    // ==========================================================
    // Checking and transfer tasks
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic t(input logic ap, input logic rd, input logic [1:0] a, input logic [31:0] wd,
                     input logic [1:0] bad, input logic [2:0] eack);
        logic [2:0] ack;
        logic pok;
        i_swa_host_model.xfer(ap, rd, a, wd, bad, ack, rd_v, pok);
        chk({29'h0, ack}, {29'h0, eack});
        if (rd && eack == ACK_OK) chk({31'h0, pok}, 32'h1);
    endtask : t

    task automatic settle();
        for (int i = 0; i < 4000 && busy_cnt != 0; i++) @(posedge clk_i);
        repeat (4) @(posedge clk_i);
    endtask : settle

    task automatic final_report();
        $display("checks %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : final_report

    initial begin
        repeat (60000) @(posedge clk_i);
        mismatches++;
        final_report();
    end

    // ==========================================================
    // Scenarios
    initial begin
        ap_val = 32'hC0DE_1234;
        repeat (6) @(posedge clk_i);
        rst_n_i <= 1'b1;
        repeat (4) @(posedge clk_i);
        chk(ctrl_stat_o, CS_RESET);
        chk(select_o, SEL_RESET);
        chk(wcr_o, WCR_RESET);
        chk({31'h0, swdio_oe_o}, 32'h0);
        t(1'b0, 1'b1, A_ID_ABORT, 32'h0, 2'h0, ACK_OK);
        chk(rd_v, ID_V);
        t(1'b0, 1'b0, A_RESEND_SEL, 32'h0000_0031, 2'h0, ACK_OK);
        chk(select_o, 32'h0000_0031);
        t(1'b0, 1'b0, A_CTRL, 32'h0000_00A5, 2'h0, ACK_OK);
        chk(wcr_o, 32'h0000_00A5);
        t(1'b0, 1'b1, A_CTRL, 32'h0, 2'h0, ACK_OK);
        chk(rd_v, 32'h0000_00A5);
        t(1'b0, 1'b0, A_RESEND_SEL, 32'h0000_0030, 2'h0, ACK_OK);
        // Slow port: later requests land while the read is outstanding
        ap_delay = 1500;
        t(1'b1, 1'b1, 2'h2, 32'h0, 2'h0, ACK_OK);
        chk({25'h0, last_cmd.wr, last_cmd.addr}, {25'h0, 1'b0, 4'h3, 2'h2});
        t(1'b1, 1'b1, 2'h1, 32'h0, 2'h0, ACK_WAIT);
        t(1'b0, 1'b1, A_READ_BUFFER_REG, 32'h0, 2'h0, ACK_WAIT);
        t(1'b0, 1'b1, A_CTRL, 32'h0, 2'h0, ACK_OK);
        chk({31'h0, rd_v[CS_READ_SUCCESS_FLAG]}, 32'h0);
        settle();
        t(1'b0, 1'b1, A_READ_BUFFER_REG, 32'h0, 2'h0, ACK_OK);
        chk(rd_v, ap_val);
        t(1'b0, 1'b1, A_RESEND_SEL, 32'h0, 2'h0, ACK_OK);
        chk(rd_v, ap_val);
        t(1'b0, 1'b1, A_CTRL, 32'h0, 2'h0, ACK_OK);
        chk({31'h0, rd_v[CS_READ_SUCCESS_FLAG]}, 32'h1);
        ap_delay = 4;
        t(1'b1, 1'b0, 2'h1, 32'h5A5A_0F0F, 2'h0, ACK_OK);
        settle();
        chk({25'h0, last_cmd.wr, last_cmd.addr}, {25'h0, 1'b1, 4'h3, 2'h1});
        chk(last_cmd.wdata, 32'h5A5A_0F0F);
        // Pushed verify with a mismatching payload raises the compare flag
        t(1'b0, 1'b0, A_CTRL, 32'h0000_0004, 2'h0, ACK_OK);
        t(1'b1, 1'b0, 2'h0, 32'h1111_2222, 2'h0, ACK_OK);
        settle();
        chk({31'h0, last_cmd.wr}, 32'h0);
        t(1'b0, 1'b1, A_CTRL, 32'h0, 2'h0, ACK_OK);
        chk({31'h0, rd_v[CS_STICKYCMP]}, 32'h1);
        t(1'b0, 1'b1, A_ID_ABORT, 32'h0, 2'h0, ACK_OK);
        t(1'b1, 1'b1, 2'h0, 32'h0, 2'h0, ACK_FAULT);
        t(1'b0, 1'b1, A_READ_BUFFER_REG, 32'h0, 2'h0, ACK_FAULT);
        t(1'b1, 1'b0, 2'h0, 32'h0, 2'h0, ACK_FAULT);
        t(1'b0, 1'b0, A_RESEND_SEL, 32'h0, 2'h0, ACK_FAULT);
        t(1'b0, 1'b0, A_ID_ABORT, 32'h0000_001F, 2'h0, ACK_OK);
        chk(n_abort, 32'h1);
        t(1'b0, 1'b1, A_CTRL, 32'h0, 2'h0, ACK_OK);
        chk(rd_v & 32'h0000_00B2, 32'h0);
        // Overrun detection on, slow failing port
        t(1'b0, 1'b0, A_CTRL, 32'h0000_0001, 2'h0, ACK_OK);
        i_swa_host_model.orun = 1'b1;
        ap_delay = 1500;
        ap_err_v = 1'b1;
        t(1'b1, 1'b1, 2'h0, 32'h0, 2'h0, ACK_OK);
        t(1'b1, 1'b1, 2'h0, 32'h0, 2'h0, ACK_WAIT);
        t(1'b1, 1'b0, 2'h0, 32'h0, 2'h0, ACK_FAULT);
        t(1'b0, 1'b1, A_CTRL, 32'h0, 2'h0, ACK_OK);
        chk({30'h0, rd_v[CS_STICKYERR], rd_v[CS_STICKYORUN]}, 32'h3);
        t(1'b0, 1'b0, A_ID_ABORT, 32'h0000_0015, 2'h0, ACK_OK);
        ap_delay = 4;
        ap_err_v = 1'b0;
        i_swa_host_model.orun = 1'b0;
        t(1'b0, 1'b0, A_CTRL, 32'h0, 2'h0, ACK_OK);
        // Spoiled payload parity: acknowledged, then dropped and flagged
        t(1'b1, 1'b0, 2'h3, 32'h0F0F_0001, 2'h2, ACK_OK);
        repeat (20) @(posedge clk_i);
        chk(n_req, 32'h4);
        t(1'b0, 1'b1, A_CTRL, 32'h0, 2'h0, ACK_OK);
        chk({31'h0, rd_v[CS_WRITE_DATA_ERROR_FLAG]}, 32'h1);
        t(1'b0, 1'b1, A_ID_ABORT, 32'h0, 2'h1, ACK_RESET);
        t(1'b0, 1'b1, A_ID_ABORT, 32'h0, 2'h0, ACK_OK);
        chk(rd_v, ID_V);
        final_report();
    end
endmodule : swa_target_tb
`default_nettype wire
